// file: logic/csb_unit.sv
// Overview of operation
// [RULE1] Indirect call loads PC[15:0] from Z, clears PC[21:16], and takes 2 or 3 cycles.
// [RULE2] Extended indirect call loads PC[15:0] from Z and PC[21:16] from the extended register in 3 cycles, flags kept.
// [RULE3] Compare-skip-equal skips the next instruction when both registers match, flags kept, in 1, 2 or 3 cycles.
// [RULE4] Compares subtract the second operand (plus carry for the carry form) and update Z, C, N, V, S, H in 1 cycle.
// [RULE5] Register-bit skips test one bit of a working register and skip on a match, flags kept, in 1, 2 or 3 cycles.
// [RULE6] I/O-bit skips test one I/O bit and skip on a match, flags kept, in 2, 3 or 4 cycles.
// [RULE7] Generic status-bit branches jump to PC plus offset plus one when the bit matches, 1 cycle or 2 when taken.
// [RULE8] Equal, not-equal, carry, lower, same-or-higher, minus and plus branches are fixed-flag generic branches.
// [RULE9] Signed greater-or-equal takes on N xor V equal 0, signed less-than on 1, in 1 or 2 cycles.
// [RULE10] Half-carry branches take on H set or cleared with the usual target and timing.
// [RULE11] Transfer-bit branches take on T set or cleared, jumping to PC plus offset plus one in 1 or 2 cycles.
// [RULE12] Overflow branches take on V set or cleared without touching flags in 1 or 2 cycles.
// [RULE13] Interrupt-state branches take on I set or cleared with the usual target and timing.
// [RULE14] The branch offset is signed two's complement and a skip advances PC by 2 or 3 by skipped length.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module csb_unit (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  // Instruction request
  input  wire logic        start_in,
  input  wire logic [4:0]  op_in,
  input  wire logic [7:0]  rd_val_in,
  input  wire logic [7:0]  rr_val_in,
  input  wire logic [2:0]  bit_sel_in,
  input  wire logic [6:0]  offset_in,
  input  wire logic        io_bit_in,
  input  wire logic        next_two_word_in,
  // Core state
  input  wire logic [21:0] pc_in,
  input  wire logic [15:0] z_ptr_in,
  input  wire logic [7:0]  status_register_in,
  // Register port
  input  wire logic [1:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_we_in,
  input  wire logic        reg_re_in,
  output logic      [7:0]  reg_rdata_out,
  // Result
  output logic             busy_out,
  output logic             done_out,
  output logic             pc_load_out,
  output logic      [21:0] pc_out,
  output logic             status_we_out,
  output logic      [7:0]  status_register_out,
  output logic      [2:0]  cycles_out
);

  // Maps a generic or fixed-flag branch to its status bit and wanted value
  function automatic logic [3:0] branch_sel(input logic [4:0] op, input logic [2:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (op)
      csb_pkg::OP_BR_STATUS_BIT_SET:   r = {1'b1, sel}; // [RULE7]
      csb_pkg::OP_BR_STATUS_BIT_CLEAR: r = {1'b0, sel}; // [RULE7]
      csb_pkg::OP_BR_EQUAL:            r = {1'b1, csb_pkg::SB_Z}; // [RULE8]
      csb_pkg::OP_BR_NOT_EQUAL:        r = {1'b0, csb_pkg::SB_Z}; // [RULE8]
      csb_pkg::OP_BR_CARRY_SET:        r = {1'b1, csb_pkg::SB_C}; // [RULE8]
      csb_pkg::OP_BR_LOWER:            r = {1'b1, csb_pkg::SB_C}; // [RULE8]
      csb_pkg::OP_BR_CARRY_CLEAR:      r = {1'b0, csb_pkg::SB_C}; // [RULE8]
      csb_pkg::OP_BR_SAME_OR_HIGHER:   r = {1'b0, csb_pkg::SB_C}; // [RULE8]
      csb_pkg::OP_BR_MINUS:            r = {1'b1, csb_pkg::SB_N}; // [RULE8]
      csb_pkg::OP_BR_PLUS:             r = {1'b0, csb_pkg::SB_N}; // [RULE8]
      csb_pkg::OP_BR_SIGNED_GE:        r = {1'b0, csb_pkg::SB_S}; // [RULE9]
      csb_pkg::OP_BR_SIGNED_LT:        r = {1'b1, csb_pkg::SB_S}; // [RULE9]
      csb_pkg::OP_BR_HALF_CARRY_SET:   r = {1'b1, csb_pkg::SB_H}; // [RULE10]
      csb_pkg::OP_BR_HALF_CARRY_CLEAR: r = {1'b0, csb_pkg::SB_H}; // [RULE10]
      csb_pkg::OP_BR_TRANSFER_SET:     r = {1'b1, csb_pkg::SB_T}; // [RULE11]
      csb_pkg::OP_BR_TRANSFER_CLEAR:   r = {1'b0, csb_pkg::SB_T}; // [RULE11]
      csb_pkg::OP_BR_OVERFLOW_SET:     r = {1'b1, csb_pkg::SB_V}; // [RULE12]
      csb_pkg::OP_BR_OVERFLOW_CLEAR:   r = {1'b0, csb_pkg::SB_V}; // [RULE12]
      csb_pkg::OP_BR_IRQ_ENABLED:      r = {1'b1, csb_pkg::SB_I}; // [RULE13]
      csb_pkg::OP_BR_IRQ_DISABLED:     r = {1'b0, csb_pkg::SB_I}; // [RULE13]
      default:                         r = 4'h0;
    endcase
    return r;
  endfunction

  csb_pkg::csb_state_t state;
  logic [2:0]          cnt;
  logic [7:0]          ext_ind;
  logic [7:0]          ctrl;
  logic                last_taken;

  logic                accept;
  logic                next_load;
  logic [21:0]         next_pc;
  logic                next_flag_we;
  logic [7:0]          next_flags;
  logic [2:0]          next_cycles;
  logic                next_taken;

  logic [7:0]          diff;
  logic                carry_in;
  logic                is_branch;
  logic [3:0]          bsel;
  logic                sign_v;
  logic                test_bit;
  logic [21:0]         skip_step;
  logic [2:0]          skip_cycles;
  logic [21:0]         rel_target;

  assign done_out = (state == csb_pkg::ST_BUSY) && (cnt == 3'h0);
  assign busy_out = (state == csb_pkg::ST_BUSY) && (cnt != 3'h0);
  // Back to back: a new request may join the done cycle
  assign accept   = start_in && !busy_out;

  assign carry_in   = (op_in == csb_pkg::OP_COMPARE_REGS_CARRY) ? status_register_in[csb_pkg::SB_C] : 1'b0;
  assign diff       = rd_val_in - rr_val_in - {7'h00, carry_in}; // [RULE4]
  assign is_branch  = (op_in >= csb_pkg::OP_BR_STATUS_BIT_SET) && (op_in <= csb_pkg::OP_BR_IRQ_DISABLED);
  assign bsel       = branch_sel(op_in, bit_sel_in);
  // Signed forms test N xor V live, not the stored S bit
  assign sign_v     = status_register_in[csb_pkg::SB_N] ^ status_register_in[csb_pkg::SB_V]; // [RULE9]
  assign test_bit   = (bsel[2:0] == csb_pkg::SB_S &&
                      (op_in == csb_pkg::OP_BR_SIGNED_GE || op_in == csb_pkg::OP_BR_SIGNED_LT))
                      ? sign_v : status_register_in[bsel[2:0]];
  // Two-word victim needs one more step and one more cycle
  assign skip_step   = next_two_word_in ? csb_pkg::PC_STEP_THR : csb_pkg::PC_STEP_TWO; // [RULE14]
  assign skip_cycles = next_two_word_in ? csb_pkg::CYC_SKIP_TWO_WORD : csb_pkg::CYC_SKIP_ONE_WORD;
  assign rel_target  = pc_in + {{15{offset_in[6]}}, offset_in} + csb_pkg::PC_STEP_ONE; // [RULE7] [RULE14]

  always_comb begin
    next_load    = 1'b1;
    next_pc      = pc_in + csb_pkg::PC_STEP_ONE;
    next_flag_we = 1'b0;
    next_flags   = status_register_in;
    next_cycles  = csb_pkg::CYC_ONE;
    next_taken   = 1'b0;
    case (op_in)
      csb_pkg::OP_INDIRECT_CALL: begin
        next_pc     = {6'h00, z_ptr_in}; // [RULE1]
        next_taken  = 1'b1;
        next_cycles = ctrl[csb_pkg::CTRL_WIDE_PC_BIT] ? csb_pkg::CYC_IND_CALL_22 : csb_pkg::CYC_IND_CALL_16; // [RULE1]
      end
      csb_pkg::OP_EXT_INDIRECT_CALL: begin
        next_pc     = {ext_ind[5:0], z_ptr_in}; // [RULE2]
        next_taken  = 1'b1;
        next_cycles = csb_pkg::CYC_EXT_CALL; // [RULE2]
      end
      csb_pkg::OP_COMPARE_SKIP_EQUAL: begin
        if (rd_val_in == rr_val_in) begin // [RULE3]
          next_pc     = pc_in + skip_step;
          next_cycles = skip_cycles;
          next_taken  = 1'b1;
        end
      end
      csb_pkg::OP_COMPARE_REGS,
      csb_pkg::OP_COMPARE_REGS_CARRY,
      csb_pkg::OP_COMPARE_IMMEDIATE: begin
        next_flag_we = 1'b1; // [RULE4]
        next_flags[csb_pkg::SB_H] = (~rd_val_in[3] & rr_val_in[3]) | (rr_val_in[3] & diff[3]) |
                                    (diff[3] & ~rd_val_in[3]);
        next_flags[csb_pkg::SB_C] = (~rd_val_in[7] & rr_val_in[7]) | (rr_val_in[7] & diff[7]) |
                                    (diff[7] & ~rd_val_in[7]);
        next_flags[csb_pkg::SB_V] = (rd_val_in[7] & ~rr_val_in[7] & ~diff[7]) |
                                    (~rd_val_in[7] & rr_val_in[7] & diff[7]);
        next_flags[csb_pkg::SB_N] = diff[7];
        next_flags[csb_pkg::SB_S] = diff[7] ^ next_flags[csb_pkg::SB_V];
        // Carry form keeps Z sticky across multi-byte compares
        if (op_in == csb_pkg::OP_COMPARE_REGS_CARRY) begin
          next_flags[csb_pkg::SB_Z] = (diff == 8'h00) & status_register_in[csb_pkg::SB_Z];
        end else begin
          next_flags[csb_pkg::SB_Z] = (diff == 8'h00);
        end
      end
      csb_pkg::OP_SKIP_REG_BIT_CLEAR,
      csb_pkg::OP_SKIP_REG_BIT_SET: begin
        if (rd_val_in[bit_sel_in] == (op_in == csb_pkg::OP_SKIP_REG_BIT_SET)) begin // [RULE5]
          next_pc     = pc_in + skip_step;
          next_cycles = skip_cycles;
          next_taken  = 1'b1;
        end
      end
      csb_pkg::OP_SKIP_IO_BIT_CLEAR,
      csb_pkg::OP_SKIP_IO_BIT_SET: begin
        next_cycles = csb_pkg::CYC_ONE + csb_pkg::CYC_IO_EXTRA; // [RULE6]
        if (io_bit_in == (op_in == csb_pkg::OP_SKIP_IO_BIT_SET)) begin // [RULE6]
          next_pc     = pc_in + skip_step;
          next_cycles = skip_cycles + csb_pkg::CYC_IO_EXTRA;
          next_taken  = 1'b1;
        end
      end
      default: begin
        if (is_branch && (test_bit == bsel[3])) begin // [RULE7] [RULE8] [RULE10] [RULE11] [RULE12] [RULE13]
          next_pc     = rel_target;
          next_cycles = csb_pkg::CYC_BR_TAKEN;
          next_taken  = 1'b1;
        end else if (!is_branch) begin
          // Unknown code: finish quietly, leave PC to the core
          next_load = 1'b0;
        end
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= csb_pkg::ST_IDLE;
      cnt   <= 3'h0;
    end else if (accept) begin
      state <= csb_pkg::ST_BUSY;
      cnt   <= next_cycles - 3'h1;
    end else if (done_out) begin
      state <= csb_pkg::ST_IDLE;
    end else if (state == csb_pkg::ST_BUSY) begin
      cnt <= cnt - 3'h1;
    end
  end

  // Results held until the next request
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pc_out              <= 22'h000000;
      pc_load_out         <= 1'b0;
      status_register_out <= 8'h00;
      status_we_out       <= 1'b0;
      cycles_out          <= 3'h0;
      last_taken          <= 1'b0;
    end else if (accept) begin
      pc_out              <= next_pc;
      pc_load_out         <= next_load;
      status_register_out <= next_flags; // [RULE2] [RULE3] [RULE5] [RULE6] [RULE12]
      status_we_out       <= next_flag_we;
      cycles_out          <= next_cycles;
      last_taken          <= next_taken;
    end
  end

  // Register port writes
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ext_ind <= csb_pkg::RST_EXT_IND;
      ctrl    <= csb_pkg::RST_CTRL;
    end else if (reg_we_in) begin
      case (reg_addr_in)
        csb_pkg::OFS_EXT_IND: ext_ind <= {2'h0, reg_wdata_in[5:0]};
        csb_pkg::OFS_CTRL:    ctrl    <= {7'h00, reg_wdata_in[csb_pkg::CTRL_WIDE_PC_BIT]};
        default:              ;
      endcase
    end
  end

  // Register port reads, one cycle later; unmapped reads zero
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_re_in) begin
      case (reg_addr_in)
        csb_pkg::OFS_EXT_IND: reg_rdata_out <= ext_ind;
        csb_pkg::OFS_CTRL:    reg_rdata_out <= ctrl;
        csb_pkg::OFS_STAT:    reg_rdata_out <= {3'h0, last_taken, busy_out, cycles_out};
        default:              reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// file: pkg/csb_pkg.sv
`default_nettype none
package csb_pkg;

  // Status register bit positions
  localparam logic [2:0] SB_C = 3'h0;
  localparam logic [2:0] SB_Z = 3'h1;
  localparam logic [2:0] SB_N = 3'h2;
  localparam logic [2:0] SB_V = 3'h3;
  localparam logic [2:0] SB_S = 3'h4;
  localparam logic [2:0] SB_H = 3'h5;
  localparam logic [2:0] SB_T = 3'h6;
  localparam logic [2:0] SB_I = 3'h7;

  // Register port offsets
  localparam logic [1:0] OFS_EXT_IND = 2'h0;
  localparam logic [1:0] OFS_CTRL    = 2'h1;
  localparam logic [1:0] OFS_STAT    = 2'h2;

  // Field positions
  localparam int CTRL_WIDE_PC_BIT = 0;
  localparam int STAT_BUSY_BIT    = 3;
  localparam int STAT_TAKEN_BIT   = 4;

  // Reset values
  localparam logic [7:0] RST_EXT_IND = 8'h00;
  localparam logic [7:0] RST_CTRL    = 8'h01;

  // Cycle counts
  localparam logic [2:0] CYC_ONE           = 3'h1;
  localparam logic [2:0] CYC_IND_CALL_16   = 3'h2;
  localparam logic [2:0] CYC_IND_CALL_22   = 3'h3;
  localparam logic [2:0] CYC_EXT_CALL      = 3'h3;
  localparam logic [2:0] CYC_IO_EXTRA      = 3'h1;
  localparam logic [2:0] CYC_SKIP_ONE_WORD = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO_WORD = 3'h3;
  localparam logic [2:0] CYC_BR_TAKEN      = 3'h2;

  // Program counter advances
  localparam logic [21:0] PC_STEP_ONE = 22'h000001;
  localparam logic [21:0] PC_STEP_TWO = 22'h000002;
  localparam logic [21:0] PC_STEP_THR = 22'h000003;

  typedef enum logic [4:0] {
    OP_INDIRECT_CALL       = 5'b00000,
    OP_EXT_INDIRECT_CALL   = 5'b00001,
    OP_COMPARE_SKIP_EQUAL  = 5'b00010,
    OP_COMPARE_REGS        = 5'b00011,
    OP_COMPARE_REGS_CARRY  = 5'b00100,
    OP_COMPARE_IMMEDIATE   = 5'b00101,
    OP_SKIP_REG_BIT_CLEAR  = 5'b00110,
    OP_SKIP_REG_BIT_SET    = 5'b00111,
    OP_SKIP_IO_BIT_CLEAR   = 5'b01000,
    OP_SKIP_IO_BIT_SET     = 5'b01001,
    OP_BR_STATUS_BIT_SET   = 5'b01010,
    OP_BR_STATUS_BIT_CLEAR = 5'b01011,
    OP_BR_EQUAL            = 5'b01100,
    OP_BR_NOT_EQUAL        = 5'b01101,
    OP_BR_CARRY_SET        = 5'b01110,
    OP_BR_CARRY_CLEAR      = 5'b01111,
    OP_BR_SAME_OR_HIGHER   = 5'b10000,
    OP_BR_LOWER            = 5'b10001,
    OP_BR_MINUS            = 5'b10010,
    OP_BR_PLUS             = 5'b10011,
    OP_BR_SIGNED_GE        = 5'b10100,
    OP_BR_SIGNED_LT        = 5'b10101,
    OP_BR_HALF_CARRY_SET   = 5'b10110,
    OP_BR_HALF_CARRY_CLEAR = 5'b10111,
    OP_BR_TRANSFER_SET     = 5'b11000,
    OP_BR_TRANSFER_CLEAR   = 5'b11001,
    OP_BR_OVERFLOW_SET     = 5'b11010,
    OP_BR_OVERFLOW_CLEAR   = 5'b11011,
    OP_BR_IRQ_ENABLED      = 5'b11100,
    OP_BR_IRQ_DISABLED     = 5'b11101
  } csb_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } csb_state_t;

endpackage
`default_nettype wire

// file: verif/csb_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module csb_unit_properties (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  // Request and core state
  input wire logic        start_in,
  input wire logic [4:0]  op_in,
  input wire logic [7:0]  rd_val_in,
  input wire logic [2:0]  bit_sel_in,
  input wire logic [6:0]  offset_in,
  input wire logic        io_bit_in,
  input wire logic        next_two_word_in,
  input wire logic [21:0] pc_in,
  input wire logic [15:0] z_ptr_in,
  input wire logic [7:0]  status_register_in,
  // Result
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic [21:0] pc_out,
  input wire logic        status_we_out,
  input wire logic [7:0]  status_register_out,
  input wire logic [2:0]  cycles_out
);
  wire logic [21:0] off_ext = {{15{offset_in[6]}}, offset_in};
  wire logic        nv      = status_register_in[2] ^ status_register_in[3];
  wire logic        is_cmp  = op_in inside {5'h03, 5'h04, 5'h05};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_acc(logic [4:0] o);
    start_in && !busy_out && op_in == o;
  endsequence
  sequence s_three;
    busy_out ##1 busy_out ##1 done_out;
  endsequence
  property p_ind_call;
    s_acc(csb_pkg::OP_INDIRECT_CALL) |=> pc_out == {6'h00, $past(z_ptr_in)} && cycles_out inside {3'h2, 3'h3};
  endproperty
  a_ind_call: assert property (p_ind_call) else $error("indirect call target or count wrong");
  property p_ext_call;
    s_acc(csb_pkg::OP_EXT_INDIRECT_CALL) |=> pc_out[15:0] == $past(z_ptr_in) && !status_we_out ##0 s_three;
  endproperty
  a_ext_call: assert property (p_ext_call) else $error("extended call not three cycles");
  property p_cmp;
    start_in && !busy_out && is_cmp |=> done_out && status_we_out && cycles_out == 3'h1;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare not one cycle with flag write");
  property p_skip_reg;
    s_acc(csb_pkg::OP_SKIP_REG_BIT_SET) ##0 rd_val_in[bit_sel_in] |=>
      cycles_out == ($past(next_two_word_in) ? 3'h3 : 3'h2) && pc_out == $past(pc_in) + {20'h0, cycles_out[1:0]};
  endproperty
  a_skip_reg: assert property (p_skip_reg) else $error("register bit skip wrong");
  property p_skip_io;
    s_acc(csb_pkg::OP_SKIP_IO_BIT_CLEAR) ##0 !io_bit_in |=> cycles_out == ($past(next_two_word_in) ? 3'h4 : 3'h3);
  endproperty
  a_skip_io: assert property (p_skip_io) else $error("io bit skip count wrong");
  property p_taken;
    s_acc(csb_pkg::OP_BR_EQUAL) ##0 status_register_in[1] |=>
      pc_out == $past(pc_in) + $past(off_ext) + 22'h1 && cycles_out == 3'h2 ##1 done_out;
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch target or timing wrong");
  property p_not_taken;
    s_acc(csb_pkg::OP_BR_NOT_EQUAL) ##0 status_register_in[1] |=> done_out && pc_out == $past(pc_in) + 22'h1;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("untaken branch wrong");
  property p_signed;
    s_acc(csb_pkg::OP_BR_SIGNED_LT) |=> cycles_out == ($past(nv) ? 3'h2 : 3'h1);
  endproperty
  a_signed: assert property (p_signed) else $error("signed branch condition wrong");
  property p_flags_kept;
    start_in && !busy_out && !is_cmp |=> !status_we_out && status_register_out == $past(status_register_in);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");
endmodule
bind csb_unit csb_unit_properties csb_unit_properties_inst (.mclk_in, .sys_rst_in, .start_in, .op_in,
  .rd_val_in, .bit_sel_in, .offset_in, .io_bit_in, .next_two_word_in, .pc_in, .z_ptr_in,
  .status_register_in, .busy_out, .done_out, .pc_out, .status_we_out, .status_register_out, .cycles_out);
`default_nettype wire

// file: verif/csb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core PC and status register; preset before each instruction so
// expectations never lean on earlier results of the unit
module csb_core_model (
  // Clock
  input wire logic        mclk_in,
  // Preset
  input wire logic        load_in,
  input wire logic [21:0] pc_val_in,
  input wire logic [7:0]  flags_val_in,
  // Core state
  output logic     [21:0] pc_out,
  output logic     [7:0]  flags_out
);
  always_ff @(posedge mclk_in) begin
    if (load_in) begin
      pc_out <= pc_val_in;
      flags_out <= flags_val_in;
    end
  end
endmodule
`default_nettype wire

// file: verif/test_cpu_compare_skip_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_compare_skip_branch_unit;
  typedef struct {logic [21:0] pc; logic [2:0] cyc; logic ld; logic chk; logic swe; logic [7:0] fl; time t;} csb_exp_t;
  logic mclk_in = 0, sys_rst_in = 1, start_in = 0, io_bit_in = 0, next_two_word_in = 0;
  logic reg_we_in = 0, reg_re_in = 0, load = 0, wide = 1;
  logic [4:0] op_in = 0;
  logic [7:0] rd_val_in = 0, rr_val_in = 0, reg_wdata_in = 0, reg_rdata_out, fl_v = 0, core_fl, status_register_out, ext = 0;
  logic [2:0] bit_sel_in = 0, cycles_out;
  logic [6:0] offset_in = 0;
  logic [1:0] reg_addr_in = 0;
  logic [15:0] z_ptr_in = 0;
  logic [21:0] pc_v = 0, core_pc, pc_out;
  logic busy_out, done_out, pc_load_out, status_we_out;
  logic [31:0] seed, r1, r2;
  int errors = 0, comparisons = 0;
  csb_exp_t q[$];
  csb_exp_t m;
  always #5 mclk_in = ~mclk_in;
  csb_core_model csb_core_model_inst (.mclk_in(mclk_in), .load_in(load), .pc_val_in(pc_v),
    .flags_val_in(fl_v), .pc_out(core_pc), .flags_out(core_fl));
  csb_unit csb_unit_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .op_in(op_in),
    .rd_val_in(rd_val_in), .rr_val_in(rr_val_in), .bit_sel_in(bit_sel_in), .offset_in(offset_in),
    .io_bit_in(io_bit_in), .next_two_word_in(next_two_word_in), .pc_in(core_pc), .z_ptr_in(z_ptr_in),
    .status_register_in(core_fl), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_we_in(reg_we_in), .reg_re_in(reg_re_in), .reg_rdata_out(reg_rdata_out), .busy_out(busy_out),
    .done_out(done_out), .pc_load_out(pc_load_out), .pc_out(pc_out), .status_we_out(status_we_out),
    .status_register_out(status_register_out), .cycles_out(cycles_out));
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic br_take(input logic [4:0] o, input logic [7:0] f, input logic [2:0] b);
    logic c;
    case (o)
      5'h0A, 5'h0B: c = f[b];
      5'h0C, 5'h0D: c = f[1];
      5'h0E, 5'h0F, 5'h10, 5'h11: c = f[0];
      5'h12, 5'h13: c = f[2];
      5'h14, 5'h15: c = f[2] ^ f[3];
      5'h16, 5'h17: c = f[5];
      5'h18, 5'h19: c = f[6];
      5'h1A, 5'h1B: c = f[3];
      default: c = f[7];
    endcase
    // Same-or-higher, lower and both signed forms invert the odd-is-clear pattern
    return c ^ o[0] ^ (o[4:1] == 4'h8 || o[4:1] == 4'hA);
  endfunction
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_we_in <= 1'b1;
    @(posedge mclk_in);
    reg_we_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp);
    reg_addr_in <= a;
    reg_re_in <= 1'b1;
    @(posedge mclk_in);
    reg_re_in <= 1'b0;
    @(posedge mclk_in);
    chk(reg_rdata_out, exp);
  endtask
  task automatic issue(input logic [4:0] op, input logic [7:0] rd, rr, fl, input logic [2:0] b,
                       input logic [6:0] off, input logic io, two, input logic [21:0] pc, input logic [15:0] z,
                       input int hold);
    csb_exp_t e;
    logic [8:0] r;
    logic [4:0] h;
    logic c, sk;
    int n;
    load <= 1'b1;
    pc_v <= pc;
    fl_v <= fl;
    @(posedge mclk_in);
    load <= 1'b0;
    start_in <= 1'b1;
    op_in <= op;
    rd_val_in <= rd;
    rr_val_in <= rr;
    bit_sel_in <= b;
    offset_in <= off;
    io_bit_in <= io;
    next_two_word_in <= two;
    z_ptr_in <= z;
    e = '{pc + 22'h1, 3'h1, 1'b1, 1'b1, 1'b0, fl, $time + 10};
    case (op)
      5'h00: begin e.pc = {6'h00, z}; e.cyc = wide ? 3'h3 : 3'h2; end
      5'h01: begin e.pc = {ext[5:0], z}; e.cyc = 3'h3; end
      5'h03, 5'h04, 5'h05: begin
        c = (op == 5'h04) & fl[0];
        r = {1'b0, rd} - {1'b0, rr} - {8'h00, c};
        h = {1'b0, rd[3:0]} - {1'b0, rr[3:0]} - {4'h0, c};
        e.chk = 1'b0;
        e.swe = 1'b1;
        e.fl[5:0] = {h[4], r[7] ^ ((rd[7] & ~rr[7] & ~r[7]) | (~rd[7] & rr[7] & r[7])),
                     (rd[7] & ~rr[7] & ~r[7]) | (~rd[7] & rr[7] & r[7]), r[7],
                     r[7:0] == 8'h00 && (op != 5'h04 || fl[1]), r[8]};
      end
      5'h02, 5'h06, 5'h07, 5'h08, 5'h09: begin
        sk = op == 5'h02 ? rd == rr : op == 5'h06 ? !rd[b] : op == 5'h07 ? rd[b] : op == 5'h08 ? !io : io;
        if (sk) begin e.pc = pc + (two ? 22'h3 : 22'h2); e.cyc = two ? 3'h3 : 3'h2; end
        if (op[3]) e.cyc = e.cyc + 3'h1;
      end
      5'h1E, 5'h1F: e.ld = 1'b0;
      default: if (br_take(op, fl, b)) begin e.pc = pc + {{15{off[6]}}, off} + 22'h1; e.cyc = 3'h2; end
    endcase
    q.push_back(e);
    repeat (hold) @(posedge mclk_in);
    start_in <= 1'b0;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (done_out !== 1'b1 && n < 8);
  endtask
  always @(posedge mclk_in) begin
    if (sys_rst_in === 1'b0 && done_out === 1'b1) begin
      if (q.size() == 0) begin
        errors++;
        $display("ERROR %0t: result with no request", $time);
      end else begin
        m = q.pop_front();
        chk(cycles_out, m.cyc);
        chk(22'(($time - m.t) / 10), m.cyc);
        chk(status_we_out, m.swe);
        chk(status_register_out, m.fl);
        if (m.chk) chk(pc_load_out, m.ld);
        if (m.chk && m.ld) chk(pc_out, m.pc);
      end
    end
  end
  initial begin
    #200000;
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    seed = 32'hDF4A4E8F;
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    reg_rd(2'h0, 8'h00);
    reg_rd(2'h1, 8'h01);
    reg_wr(2'h0, 8'hFF);
    ext = 8'h3F;
    reg_rd(2'h0, 8'h3F);
    reg_wr(2'h3, 8'h55);
    reg_rd(2'h3, 8'h00);
    // Every operation code, plus one unknown, with random operands
    for (int i = 0; i < 372; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      issue(5'(i % 31), r1[7:0], r2[31] ? r1[7:0] : r1[15:8], r1[23:16], r1[26:24], r2[6:0], r2[7], r2[8],
            r2[30:9], {r1[31:24], r2[15:8]}, 1);
    end
    issue(5'h0C, 8'h00, 8'h00, 8'h02, 3'h0, 7'h40, 1'b0, 1'b0, 22'h000000, 16'h0000, 1);
    issue(5'h0D, 8'h00, 8'h00, 8'h00, 3'h0, 7'h3F, 1'b0, 1'b0, 22'h3FFFFF, 16'h0000, 1);
    // Start held into the busy cycle must not launch a second call
    issue(5'h01, 8'h00, 8'h00, 8'hA5, 3'h0, 7'h00, 1'b0, 1'b0, 22'h001234, 16'hBEEF, 2);
    reg_rd(2'h2, 8'h13);
    reg_wr(2'h1, 8'h00);
    wide = 1'b0;
    issue(5'h00, 8'h00, 8'h00, 8'h5A, 3'h0, 7'h00, 1'b0, 1'b0, 22'h3F0000, 16'h8001, 1);
    reg_wr(2'h1, 8'h01);
    repeat (3) @(posedge mclk_in);
    chk(22'(q.size()), 22'h0);
    // Reset after the last result has drained must bring results and registers back to rest
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    chk(pc_out, 22'h000000);
    chk(cycles_out, 3'h0);
    chk(pc_load_out, 1'b0);
    reg_rd(2'h0, 8'h00);
    reg_rd(2'h2, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
